/* rtl/mpn_mac_phy.sv */
// MAC-side nibble interface: MII transmit and receive, ENDEC receive,
// carrier and collision conditioning, transmit clock watchdog and raw
// management pins. All link clocks are sampled by the 50 MHz core clock.
`timescale 1ns/1ns
module mpn_mac_phy (
   input  wire logic        core_clk_in,
   input  wire logic        rstn_in,
   input  wire logic        mii_mode_in,
   output logic             phy_interface_select_out,
   input  wire logic        mii_tx_nibble_clock_in,
   output logic             mii_tx_enable_out,
   output logic [3:0]       mii_tx_nibble_out,
   input  wire logic        tx_frame_valid_in,
   input  wire logic [3:0]  tx_frame_nibble_in,
   input  wire logic        tx_frame_last_in,
   output logic             tx_frame_ready_out,
   input  wire logic        mii_collision_in,
   input  wire logic        mii_carrier_sense_in,
   output logic             collision_out,
   output logic             carrier_envelope_out,
   output logic             internal_clock_active_out,
   input  wire logic        mii_rx_nibble_clock_in,
   input  wire logic        mii_rx_dv_in,
   input  wire logic        mii_rx_er_in,
   input  wire logic [3:0]  mii_rx_nibble_in,
   input  wire logic        endec_rx_clock_in,
   input  wire logic        endec_rx_data_in,
   input  wire logic        endec_carrier_in,
   output logic             rx_word_valid_out,
   input  wire logic        rx_word_ready_in,
   output logic [15:0]      rx_word_out,
   output logic             rx_frame_done_out,
   output logic [15:0]      rx_status_out,
   input  wire logic        mgmt_clock_set_in,
   input  wire logic        mgmt_data_set_in,
   input  wire logic        mgmt_drive_set_in,
   output logic             mgmt_clock_out,
   output logic             mgmt_data_out,
   output logic             mgmt_data_oe_out,
   input  wire logic        mgmt_data_in,
   output logic             mgmt_data_sample_out
);

   // ==========================================================
   // Synchronisers for every signal from outside the core domain.
   logic [11:0] raw_in;
   logic [11:0] syn;
   assign raw_in = {mii_tx_nibble_clock_in, mii_rx_nibble_clock_in, mii_rx_dv_in,
                    mii_rx_er_in, mii_rx_nibble_in, mii_collision_in,
                    mii_carrier_sense_in, endec_rx_clock_in, endec_rx_data_in};

   genvar gi;
   generate
      for (gi = 0; gi < 12; gi++) begin : g_sync
         mpn_sync u_sync (
            .core_clk_in (core_clk_in),
            .rstn_in     (rstn_in),
            .async_in    (raw_in[gi]),
            .sync_out    (syn[gi])
         );
      end
   endgenerate

   logic endec_crs_s;
   logic mgmt_in_s;
   mpn_sync u_sync_crs (
      .core_clk_in (core_clk_in),
      .rstn_in     (rstn_in),
      .async_in    (endec_carrier_in),
      .sync_out    (endec_crs_s)
   );
   mpn_sync u_sync_mdi (
      .core_clk_in (core_clk_in),
      .rstn_in     (rstn_in),
      .async_in    (mgmt_data_in),
      .sync_out    (mgmt_in_s)
   );

   logic       txc_s;
   logic       rxc_s;
   logic       rxdv_s;
   logic       rxer_s;
   logic [3:0] rxd_s;
   logic       col_s;
   logic       crs_s;
   logic       erxc_s;
   logic       erxd_s;
   assign txc_s  = syn[11];
   assign rxc_s  = syn[10];
   assign rxdv_s = syn[9];
   assign rxer_s = syn[8];
   assign rxd_s  = syn[7:4];   // Line 0 is the least significant bit.
   assign col_s  = syn[3];
   assign crs_s  = syn[2];
   assign erxc_s = syn[1];
   assign erxd_s = syn[0];

   // ==========================================================
   // Edge detection of the sampled link clocks.
   logic txc_q;
   logic rxc_q;
   logic erxc_q;
   logic tx_rise;
   logic rx_rise;
   logic erx_rise;
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         txc_q  <= 1'b0;
         rxc_q  <= 1'b0;
         erxc_q <= 1'b0;
      end else begin
         txc_q  <= txc_s;
         rxc_q  <= rxc_s;
         erxc_q <= erxc_s;
      end
   end
   assign tx_rise  = txc_s && !txc_q;
   assign rx_rise  = rxc_s && !rxc_q;
   assign erx_rise = erxc_s && !erxc_q;

   // ==========================================================
   // Path select mirrored straight out to external multiplexers.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         phy_interface_select_out <= 1'b0;
      end else begin
         phy_interface_select_out <= mii_mode_in;
      end
   end

   // ==========================================================
   // Transmit clock watchdog. Without transmit clock edges (also during
   // reset) the block runs its tick from an internal divider instead.
   localparam int TO_W = $clog2(mpn_pkg::TX_CLK_TIMEOUT_CYC + 1);
   logic [TO_W-1:0] to_cnt_q;
   logic [4:0]      div_q;
   logic            int_tick;
   logic            tx_tick;
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         to_cnt_q                  <= '0;
         internal_clock_active_out <= 1'b1;
      end else if (tx_rise) begin
         to_cnt_q                  <= '0;
         internal_clock_active_out <= 1'b0;
      end else if (to_cnt_q == TO_W'(mpn_pkg::TX_CLK_TIMEOUT_CYC)) begin
         internal_clock_active_out <= 1'b1;
      end else begin
         to_cnt_q <= to_cnt_q + 1'b1;
      end
   end

   // Internal divider giving a one-cycle enable.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         div_q <= '0;
      end else if (div_q == 5'(mpn_pkg::INT_CLK_DIV - 1)) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + 1'b1;
      end
   end
   assign int_tick = (div_q == 5'(mpn_pkg::INT_CLK_DIV - 1));
   assign tx_tick  = internal_clock_active_out ? int_tick : tx_rise;

   // ==========================================================
   // Transmit outputs change only on the transmit tick or on leaving MII mode. Enable rises in
   // the same update that places the first preamble nibble, and falls
   // after the nibble flagged last has been driven.
   logic tx_last_q;
   // Ready stays low on the tick that drops enable, so no nibble is lost there.
   assign tx_frame_ready_out = tx_tick && mii_mode_in && !tx_last_q;
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         mii_tx_enable_out <= 1'b0;
         mii_tx_nibble_out <= 4'h0;
         tx_last_q         <= 1'b0;
      end else if (!mii_mode_in) begin
         mii_tx_enable_out <= 1'b0;
         mii_tx_nibble_out <= 4'h0;
         tx_last_q         <= 1'b0;
      end else if (tx_tick) begin
         if (tx_frame_valid_in && !tx_last_q) begin
            mii_tx_enable_out <= 1'b1;
            mii_tx_nibble_out <= tx_frame_nibble_in;
            tx_last_q         <= tx_frame_last_in;
         end else begin
            mii_tx_enable_out <= 1'b0;
            mii_tx_nibble_out <= 4'h0;
            tx_last_q         <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Collision is retimed to the transmit tick; MII carrier is only an
   // envelope for deferral, while the ENDEC carrier also frames receive.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         collision_out        <= 1'b0;
         carrier_envelope_out <= 1'b0;
      end else begin
         if (tx_tick) begin
            collision_out <= col_s;
         end
         carrier_envelope_out <= mii_mode_in ? crs_s : endec_crs_s;
      end
   end

   // ==========================================================
   // Receive nibble sources. MII: one aligned nibble per receive clock
   // rise. ENDEC: serial bits shifted in, aligned by the opening flag octet.
   logic       mii_stb;
   logic [3:0] mii_nib;
   logic [7:0] ser_q;
   logic [1:0] bitc_q;
   logic       ser_stb;
   logic       rx_stb;
   logic [3:0] rx_nib;
   logic       rx_act;
   mpn_pkg::mpn_rx_state_e st_q;

   assign mii_stb = mii_mode_in && rx_rise;
   assign mii_nib = rxd_s;
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         ser_q  <= 8'h00;
         bitc_q <= 2'd0;
      end else if (!mii_mode_in && erx_rise) begin
         ser_q <= {erxd_s, ser_q[7:1]};
         if (st_q == mpn_pkg::MPN_RX_HUNT) begin
            bitc_q <= 2'd0;
         end else begin
            bitc_q <= bitc_q + 1'b1;
         end
      end
   end
   assign ser_stb = !mii_mode_in && erx_rise && (bitc_q == 2'd3);
   assign rx_stb  = mii_mode_in ? mii_stb : ser_stb;
   // The bit arriving with the strobe is the nibble's top bit.
   assign rx_nib  = mii_mode_in ? mii_nib : {erxd_s, ser_q[7:5]};
   assign rx_act  = mii_mode_in ? rxdv_s : endec_crs_s;

   // ==========================================================
   // Receive state machine: hunt for the opening flag, pack nibbles into
   // words, close when the envelope drops.
   logic [1:0]  nib_q;
   logic [15:0] acc_q;
   logic        err_q;
   logic        push;
   logic        in_ready;
   logic        flag_hit;
   assign flag_hit = mii_mode_in ? (rx_nib == mpn_pkg::SFD_HIGH_NIBBLE)
                     : (erx_rise && {erxd_s, ser_q[7:1]} == mpn_pkg::OPEN_FLAG_OCTET);
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         st_q              <= mpn_pkg::MPN_RX_IDLE;
         nib_q             <= 2'd0;
         acc_q             <= 16'h0000;
         err_q             <= 1'b0;
         push              <= 1'b0;
         rx_frame_done_out <= 1'b0;
         rx_status_out     <= 16'h0000;
      end else begin
         push              <= 1'b0;
         rx_frame_done_out <= 1'b0;
         case (st_q)
            mpn_pkg::MPN_RX_IDLE: begin
               err_q <= 1'b0;
               nib_q <= 2'd0;
               if (rx_act) begin
                  st_q <= mpn_pkg::MPN_RX_HUNT;
               end
            end
            mpn_pkg::MPN_RX_HUNT: begin
               if (!rx_act) begin
                  st_q <= mpn_pkg::MPN_RX_IDLE;
               end else if ((mii_mode_in ? rx_stb : 1'b1) && flag_hit) begin
                  st_q <= mpn_pkg::MPN_RX_DATA;
               end
            end
            mpn_pkg::MPN_RX_DATA: begin
               if (!rx_act) begin
                  st_q <= mpn_pkg::MPN_RX_CLOSE;
               end else if (rx_stb) begin
                  acc_q <= {rx_nib, acc_q[15:4]};
                  nib_q <= nib_q + 1'b1;
                  if (nib_q == 2'd3) begin
                     push <= in_ready;
                  end
               end
            end
            mpn_pkg::MPN_RX_CLOSE: begin
               rx_frame_done_out <= 1'b1;
               rx_status_out <= 16'h0000;
               rx_status_out[mpn_pkg::BAD_FCS_BIT]    <= err_q;
               rx_status_out[mpn_pkg::ODD_NIBBLE_BIT] <= nib_q[0];
               st_q <= mpn_pkg::MPN_RX_IDLE;
            end
            default: begin
               st_q <= mpn_pkg::MPN_RX_IDLE;
            end
         endcase
         // Placed last so a new error wins over the idle clear.
         if (mii_mode_in && rx_stb && rx_act && rxer_s) begin
            err_q <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Word buffer toward the receive consumer; a stalled consumer holds up to
   // two words here, and a word arriving while the buffer is full is dropped.
   mpn_skid u_rx_buf (
      .core_clk_in   (core_clk_in),
      .rstn_in       (rstn_in),
      .in_valid_in   (push),
      .in_ready_out  (in_ready),
      .in_data_in    (acc_q),
      .out_valid_out (rx_word_valid_out),
      .out_ready_in  (rx_word_ready_in),
      .out_data_out  (rx_word_out)
   );

   // ==========================================================
   // Raw management pins; software owns all framing and bit timing.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         mgmt_clock_out       <= 1'b0;
         mgmt_data_out        <= 1'b0;
         mgmt_data_oe_out     <= 1'b0;
         mgmt_data_sample_out <= 1'b0;
      end else begin
         mgmt_clock_out       <= mgmt_clock_set_in;
         mgmt_data_out        <= mgmt_data_set_in;
         mgmt_data_oe_out     <= mgmt_drive_set_in;
         mgmt_data_sample_out <= mgmt_in_s;
      end
   end

endmodule

/* rtl/mpn_pkg.sv */
// Shared constants for the MAC-side nibble interface toward a PHY or ENDEC.
// Assumes a single 50 MHz core clock; all link clocks are sampled inputs.
package mpn_pkg;

   // ==========================================================
   // Timing.
   localparam int unsigned CORE_CLK_MHZ     = 50;
   localparam int unsigned TX_CLK_TIMEOUT_NS = 2000;
   localparam int unsigned TX_CLK_TIMEOUT_CYC = (TX_CLK_TIMEOUT_NS * CORE_CLK_MHZ) / 1000;
   localparam int unsigned INT_CLK_DIV      = 20;

   // ==========================================================
   // Framing patterns.
   localparam logic [7:0]  OPEN_FLAG_OCTET  = 8'hd5;
   localparam logic [7:0]  SERIAL_FLAG      = 8'hab;
   localparam logic [3:0]  PREAMBLE_NIBBLE  = 4'h5;
   localparam logic [3:0]  SFD_HIGH_NIBBLE  = 4'hd;
   localparam int unsigned RX_STATUS_WIDTH  = 16;
   localparam int unsigned BAD_FCS_BIT      = 13;
   localparam int unsigned ODD_NIBBLE_BIT   = 15;

   // ==========================================================
   // Receive state machine, Gray coded along the usual path.
   typedef enum logic [1:0] {
      MPN_RX_IDLE  = 2'b00,
      MPN_RX_HUNT  = 2'b01,
      MPN_RX_DATA  = 2'b11,
      MPN_RX_CLOSE = 2'b10
   } mpn_rx_state_e;

endpackage

/* rtl/mpn_sync.sv */
// Two flip-flop synchroniser for one level from outside the core domain.
// Assumes the input is held at least a few core cycles.
`timescale 1ns/1ns
module mpn_sync (
   input  wire logic core_clk_in,
   input  wire logic rstn_in,
   input  wire logic async_in,
   output logic      sync_out
);

   logic meta_q;

   // ==========================================================
   // The first stage feeds only the second stage.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         meta_q   <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

/* rtl/mpn_skid.sv */
// Two-entry buffer with valid and ready on both sides.
// Assumes producer and consumer share the core clock.
`timescale 1ns/1ns
module mpn_skid (
   input  wire logic        core_clk_in,
   input  wire logic        rstn_in,
   input  wire logic        in_valid_in,
   output logic             in_ready_out,
   input  wire logic [15:0] in_data_in,
   output logic             out_valid_out,
   input  wire logic        out_ready_in,
   output logic [15:0]      out_data_out
);

   logic [15:0] mem_q [2];
   logic        wr_q;
   logic        rd_q;
   logic [1:0]  cnt_q;
   logic        push;
   logic        pop;

   assign in_ready_out  = (cnt_q != 2'd2);
   assign out_valid_out = (cnt_q != 2'd0);
   assign out_data_out  = mem_q[rd_q];
   assign push          = in_valid_in && in_ready_out;
   assign pop           = out_valid_out && out_ready_in;

   // ==========================================================
   // Storage and pointers; full stalls the producer.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in) begin
         wr_q     <= 1'b0;
         rd_q     <= 1'b0;
         cnt_q    <= 2'd0;
         mem_q[0] <= 16'h0000;
         mem_q[1] <= 16'h0000;
      end else begin
         if (push) begin
            mem_q[wr_q] <= in_data_in;
            wr_q        <= ~wr_q;
         end
         if (pop) begin
            rd_q <= ~rd_q;
         end
         cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule

/* sim/mpn_mac_phy_properties.sv */
// Properties on the nibble interface top ports.
// Assumes a bind from the bench and one core clock domain.
`timescale 1ns/1ns
module mpn_mac_phy_properties (
   input logic        core_clk_in,
   input logic        rstn_in,
   input logic        mii_mode_in,
   input logic        phy_interface_select_out,
   input logic        mii_tx_nibble_clock_in,
   input logic        mii_tx_enable_out,
   input logic [3:0]  mii_tx_nibble_out,
   input logic        tx_frame_valid_in,
   input logic [3:0]  tx_frame_nibble_in,
   input logic        tx_frame_last_in,
   input logic        tx_frame_ready_out,
   input logic        internal_clock_active_out,
   input logic        mii_rx_dv_in,
   input logic        mii_rx_er_in,
   input logic        rx_frame_done_out,
   input logic [15:0] rx_status_out,
   input logic        mgmt_data_in,
   input logic        mgmt_data_sample_out
);
   // ==========================================================
   // Helper state.
   localparam logic [7:0] STOP_AGE = 8'(mpn_pkg::TX_CLK_TIMEOUT_CYC + 16);
   logic       tck_q;
   logic [7:0] rise_age_q;
   logic [7:0] still_q;
   logic       err_q;

   // Age since the transmit clock pin rose, saturating so it never wraps.
   always_ff @(posedge core_clk_in) begin
      tck_q <= mii_tx_nibble_clock_in;
      if (!rstn_in || (mii_tx_nibble_clock_in && !tck_q)) begin
         rise_age_q <= 8'h00;
      end else if (rise_age_q != 8'hff) begin
         rise_age_q <= rise_age_q + 8'h01;
      end
   end

   // Age since the transmit clock pin last moved in either direction.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in || (mii_tx_nibble_clock_in != tck_q)) begin
         still_q <= 8'h00;
      end else if (still_q != 8'hff) begin
         still_q <= still_q + 8'h01;
      end
   end

   // Remembers a receive error inside an MII frame until the frame closes.
   always_ff @(posedge core_clk_in) begin
      if (!rstn_in || rx_frame_done_out) begin
         err_q <= 1'b0;
      end else if (phy_interface_select_out && mii_rx_dv_in && mii_rx_er_in) begin
         err_q <= 1'b1;
      end
   end

   // ==========================================================
   // Properties.
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);

   sequence s_last_taken;
      phy_interface_select_out && tx_frame_valid_in && tx_frame_ready_out && tx_frame_last_in;
   endsequence
   sequence s_tail;
      mii_tx_enable_out ##[1:24] !mii_tx_enable_out;
   endsequence

   a_select_mirror: assert property (
      1 |=> phy_interface_select_out == $past(mii_mode_in))
      else $error("select output does not follow the mode");
   a_endec_quiet: assert property (
      (!phy_interface_select_out) [*2] |-> !mii_tx_enable_out)
      else $error("transmit enable high on the serial path");
   a_tx_take: assert property (
      phy_interface_select_out && tx_frame_valid_in && tx_frame_ready_out
      |=> mii_tx_enable_out && mii_tx_nibble_out == $past(tx_frame_nibble_in))
      else $error("taken nibble not on the transmit lines");
   a_tx_edge: assert property (
      !internal_clock_active_out && $changed({mii_tx_enable_out, mii_tx_nibble_out})
      |-> rise_age_q inside {[8'h01:8'h06]})
      else $error("transmit outputs moved away from a clock rise");
   a_tx_tail: assert property (s_last_taken |=> s_tail)
      else $error("transmit enable not dropped after the last nibble");
   a_rx_error: assert property (
      rx_frame_done_out && err_q |-> ##[0:1] rx_status_out[mpn_pkg::BAD_FCS_BIT])
      else $error("receive error not reported as bad check sequence");
   a_clock_timeout: assert property (
      still_q == STOP_AGE |-> internal_clock_active_out)
      else $error("stopped transmit clock not replaced");
   a_mgmt_sample: assert property (
      $stable(mgmt_data_in) [*5] |-> mgmt_data_sample_out == mgmt_data_in)
      else $error("management input not sampled");
endmodule

/* sim/mpn_phy_model.sv */
// Stand-in for the PHY and serial transceiver: clocks, frames, capture.
// Assumes the bench calls its tasks and reads tx_cap by hierarchy.
`timescale 1ns/1ns
module mpn_phy_model (
   input  logic       tx_en_in,
   input  logic [3:0] tx_nib_in,
   output logic       tx_clk_out,
   output logic       rx_clk_out,
   output logic       rx_dv_out,
   output logic       rx_er_out,
   output logic [3:0] rx_nib_out,
   output logic       ec_clk_out,
   output logic       ec_dat_out,
   output logic       ec_car_out
);
   // ==========================================================
   // Transmit side.
   logic       tx_run = 1'b1;
   logic [3:0] tx_cap[$];

   // Receive clocks stand still until a frame is sent.
   initial begin
      tx_clk_out = 1'b0;
      {rx_clk_out, rx_dv_out, rx_er_out, ec_clk_out, ec_dat_out, ec_car_out} = '0;
      rx_nib_out = 4'h0;
   end
   // The bench may stop this clock to provoke the timeout.
   always #80 if (tx_run) tx_clk_out = ~tx_clk_out;
   // Capture on our own rise, long after the MAC moved its outputs.
   always @(posedge tx_clk_out) if (tx_en_in === 1'b1) tx_cap.push_back(tx_nib_in);

   // ==========================================================
   // Receive side.
   // Two trailing clocks with valid low let the MAC see the frame end;
   // released lines show the inverse of their last value.
   task automatic mii_frame(input logic [3:0] nib[$], input int er_at);
      for (int i = 0; i < nib.size() + 2; i++) begin
         rx_dv_out = (i < nib.size());
         rx_nib_out = (i < nib.size()) ? nib[i] : ~rx_nib_out;
         rx_er_out = (i == er_at);
         #80 rx_clk_out = 1'b1;
         #80 rx_clk_out = 1'b0;
      end
   endtask

   // Serial frame: preamble, opening flag, one word, sent least bit first.
   task automatic endec_frame(input logic [15:0] w, input logic er);
      logic [31:0] b;
      b = {w, 8'hd5, 8'h55};
      ec_car_out = 1'b1;
      rx_er_out = er;
      for (int i = 0; i < 34; i++) begin
         ec_dat_out = (i < 32) ? b[i] : ~ec_dat_out;
         if (i == 32) ec_car_out = 1'b0;
         #80 ec_clk_out = 1'b1;
         #80 ec_clk_out = 1'b0;
      end
      rx_er_out = 1'b0;
   endtask
endmodule

/* sim/tb_top.sv */
// Bench for the nibble interface with a PHY stand-in and a bound checker.
// Assumes the package, design, checker and model compile before it.
`timescale 1ns/1ns
module tb_top;
   logic        core_clk_in = 1'b0, rstn_in = 1'b0, mii_mode_in = 1'b1;
   logic        tx_frame_valid_in = 1'b0, tx_frame_last_in = 1'b0;
   logic [3:0]  tx_frame_nibble_in = 4'h0;
   logic        mii_collision_in = 1'b0, mii_carrier_sense_in = 1'b0;
   logic        rx_word_ready_in = 1'b1, mgmt_data_in = 1'b0;
   logic        mgmt_clock_set_in = 1'b0, mgmt_data_set_in = 1'b0, mgmt_drive_set_in = 1'b0;
   logic        mii_tx_nibble_clock_in, mii_rx_nibble_clock_in, mii_rx_dv_in, mii_rx_er_in;
   logic        endec_rx_clock_in, endec_rx_data_in, endec_carrier_in;
   logic [3:0]  mii_rx_nibble_in, mii_tx_nibble_out;
   logic        phy_interface_select_out, mii_tx_enable_out, tx_frame_ready_out;
   logic        collision_out, carrier_envelope_out, internal_clock_active_out;
   logic        rx_word_valid_out, rx_frame_done_out, mgmt_clock_out, mgmt_data_out;
   logic        mgmt_data_oe_out, mgmt_data_sample_out;
   logic [15:0] rx_word_out, rx_status_out;
   int          err_count = 0, checked = 0, done_cnt = 0;

   mpn_mac_phy u_dut (.*);
   mpn_phy_model u_phy (
      .tx_en_in   (mii_tx_enable_out),
      .tx_nib_in  (mii_tx_nibble_out),
      .tx_clk_out (mii_tx_nibble_clock_in),
      .rx_clk_out (mii_rx_nibble_clock_in),
      .rx_dv_out  (mii_rx_dv_in),
      .rx_er_out  (mii_rx_er_in),
      .rx_nib_out (mii_rx_nibble_in),
      .ec_clk_out (endec_rx_clock_in),
      .ec_dat_out (endec_rx_data_in),
      .ec_car_out (endec_carrier_in)
   );

   // ==========================================================
   // Clock, pulse counting and shared tasks.
   always #10 core_clk_in = ~core_clk_in;
   // Done is a one-cycle pulse, so it is counted rather than polled.
   always @(posedge core_clk_in) if (rx_frame_done_out === 1'b1) done_cnt++;

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk_in);
      #1;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic conclude();
      $display("comparisons %0d mismatches %0d", checked, err_count);
      if (err_count == 0 && checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // Ready is combinational, so it is looked at mid-cycle before the taking edge.
   task automatic wait_ready();
      int n = 0;
      do begin
         @(negedge core_clk_in);
         n++;
      end while (tx_frame_ready_out !== 1'b1 && n < 200);
      if (n >= 200) chk(16'h0, 16'h1);
      tick(1);
   endtask
   task automatic pop(input logic [15:0] exp);
      chk(16'(rx_word_valid_out), 16'h1);
      chk(rx_word_out, exp);
      rx_word_ready_in = 1'b1;
      tick(1);
      rx_word_ready_in = 1'b0;
      tick(1);
   endtask

   // ==========================================================
   // Scenarios.
   task automatic t_tx();
      logic [3:0] f[$] = '{4'h5, 4'h5, 4'h5, 4'hd, 4'h3, 4'hc, 4'ha, 4'h1};
      foreach (f[i]) begin
         tx_frame_valid_in = 1'b1;
         tx_frame_nibble_in = f[i];
         tx_frame_last_in = (i == f.size() - 1);
         wait_ready();
      end
      tx_frame_valid_in = 1'b0;
      tx_frame_last_in = 1'b0;
      tick(40);
      chk(16'(u_phy.tx_cap.size()), 16'(f.size()));
      foreach (f[i]) chk(16'(u_phy.tx_cap[i]), 16'(f[i]));
      $display("test transmit done");
   endtask

   // Three words arrive while the reader stalls: two are held, one refused.
   task automatic t_rx();
      logic [3:0] f[$] = '{4'h7, 4'h5, 4'hd, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
                           4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'hc};
      rx_word_ready_in = 1'b0;
      u_phy.mii_frame(f, -1);
      tick(10);
      chk(16'(done_cnt), 16'h1);
      chk(rx_status_out & 16'ha000, 16'h0000);
      pop(16'h4321);
      pop(16'h8765);
      chk(16'(rx_word_valid_out), 16'h0);
      $display("test receive done");
   endtask

   task automatic t_err();
      logic [3:0] f[$] = '{4'h5, 4'hd, 4'h1, 4'h2, 4'h3, 4'h4};
      rx_word_ready_in = 1'b1;
      u_phy.mii_frame(f, 3);
      tick(10);
      chk(rx_status_out & 16'h2000, 16'h2000);
      rx_word_ready_in = 1'b0;
      mii_mode_in = 1'b0;
      tick(5);
      chk(16'(phy_interface_select_out), 16'h0);
      tx_frame_valid_in = 1'b1;
      u_phy.endec_frame(16'h1234, 1'b1);
      tick(10);
      tx_frame_valid_in = 1'b0;
      chk(16'(u_phy.tx_cap.size()), 16'h8);
      pop(16'h1234);
      chk(rx_status_out & 16'h2000, 16'h0000);
      chk(16'(done_cnt), 16'h3);
      mii_mode_in = 1'b1;
      tick(5);
      chk(16'(phy_interface_select_out), 16'h1);
      $display("test receive error done");
   endtask

   task automatic t_misc();
      mii_collision_in = 1'b1;
      mii_carrier_sense_in = 1'b1;
      tick(30);
      chk(16'({collision_out, carrier_envelope_out}), 16'h3);
      mii_collision_in = 1'b0;
      mii_carrier_sense_in = 1'b0;
      tick(30);
      chk(16'({collision_out, carrier_envelope_out}), 16'h0);
      u_phy.tx_run = 1'b0;
      tick(150);
      chk(16'(internal_clock_active_out), 16'h1);
      u_phy.tx_run = 1'b1;
      tick(60);
      chk(16'(internal_clock_active_out), 16'h0);
      for (int i = 0; i < 8; i++) begin
         {mgmt_clock_set_in, mgmt_data_set_in, mgmt_drive_set_in} = 3'(i);
         mgmt_data_in = i[0];
         tick(6);
         chk(16'({mgmt_clock_out, mgmt_data_out, mgmt_data_oe_out, mgmt_data_sample_out}),
             16'({3'(i), i[0]}));
      end
      $display("test side signals done");
   endtask

   // ==========================================================
   // Main sequence; outputs are checked in reset before release.
   initial begin
      tick(16);
      chk(16'(internal_clock_active_out), 16'h1);
      chk(16'({mii_tx_enable_out, rx_word_valid_out, rx_frame_done_out}), 16'h0);
      $display("test reset done");
      rstn_in = 1'b1;
      tick(20);
      t_tx();
      t_rx();
      t_err();
      t_misc();
      conclude();
   end

   // The whole run needs roughly a thousand cycles; this allows ten thousand.
   initial begin
      #200000;
      err_count++;
      conclude();
   end
endmodule

bind mpn_mac_phy mpn_mac_phy_properties u_chk (.*);
